// file: logic/sled_pkg.sv
// Package of constants and types for the status LED flash coder.
// Assumes a single 40 MHz system clock; all flash timing runs on a 10 ms tick.
package sled_pkg;

  // ----------------------------------------------------------------------
  // Clock and tick base
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned TICK_NS       = 10_000_000;
  localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS       = 10;

  // ----------------------------------------------------------------------
  // Durations in milliseconds, and in ticks
  // ----------------------------------------------------------------------
  localparam int unsigned PREOP_HALF_MS   = 1250;
  localparam int unsigned SAFEOP_HALF_MS  = 417;
  localparam int unsigned FLICKER_HALF_MS = 50;
  localparam int unsigned SHORT_MS        = 200;
  localparam int unsigned LONG_MS         = 600;
  localparam int unsigned GAP_MS          = 200;
  localparam int unsigned PAUSE_MS        = 1400;
  localparam int unsigned ACT_MS          = 50;
  localparam int unsigned SWEEP_STEP_MS   = 300;
  localparam int unsigned SWITCH_ON_MS    = 15000;

  localparam logic [7:0]  PREOP_TICKS   = 8'(PREOP_HALF_MS / TICK_MS);
  localparam logic [7:0]  SAFEOP_TICKS  = 8'(SAFEOP_HALF_MS / TICK_MS);
  localparam logic [7:0]  FLICKER_TICKS = 8'(FLICKER_HALF_MS / TICK_MS);
  localparam logic [7:0]  SHORT_TICKS   = 8'(SHORT_MS / TICK_MS);
  localparam logic [7:0]  LONG_TICKS    = 8'(LONG_MS / TICK_MS);
  localparam logic [7:0]  GAP_TICKS     = 8'(GAP_MS / TICK_MS);
  localparam logic [7:0]  PAUSE_TICKS   = 8'(PAUSE_MS / TICK_MS);
  localparam logic [7:0]  ACT_TICKS     = 8'(ACT_MS / TICK_MS);
  localparam logic [7:0]  SWEEP_TICKS   = 8'(SWEEP_STEP_MS / TICK_MS);
  localparam logic [10:0] SWON_TICKS    = 11'(SWITCH_ON_MS / TICK_MS);

  // ----------------------------------------------------------------------
  // Widths and encodings
  // ----------------------------------------------------------------------
  localparam int unsigned TYPE_W = 8;
  localparam int unsigned CFG_W  = 32;

  typedef enum logic [2:0] {
    FB_INIT   = 3'h0,
    FB_PREOP  = 3'h1,
    FB_SAFEOP = 3'h2,
    FB_BOOT   = 3'h3,
    FB_OP     = 3'h4
  } sled_fb_state_t;

  typedef enum logic [1:0] {
    PAT_SOS  = 2'h0,
    PAT_DNLD = 2'h1,
    PAT_COMM = 2'h2
  } sled_pat_t;

  typedef enum logic [1:0] {
    EL_END   = 2'h0,
    EL_SHORT = 2'h1,
    EL_LONG  = 2'h2
  } sled_elem_t;

  // Pattern table: each pattern ends with EL_END, then a long pause
  function automatic sled_elem_t sled_pat_elem(input sled_pat_t  pat,
                                               input logic [3:0] idx);
    sled_elem_t e;
    e = EL_END;
    case (pat)
      PAT_SOS: begin
        if (idx < 4'h3)      e = EL_SHORT;
        else if (idx < 4'h6) e = EL_LONG;
        else if (idx < 4'h9) e = EL_SHORT;
      end
      PAT_DNLD: begin
        if (idx < 4'h4)      e = idx[0] ? EL_LONG : EL_SHORT;
      end
      PAT_COMM: begin
        // Deliberately uneven run of short and long flashes
        case (idx)
          4'h0, 4'h1, 4'h3, 4'h6: e = EL_SHORT;
          4'h2, 4'h4, 4'h5:       e = EL_LONG;
          default:                e = EL_END;
        endcase
      end
      default: e = EL_END;
    endcase
    return e;
  endfunction : sled_pat_elem

endpackage : sled_pkg

// file: logic/sled_flash_if.sv
// Carrier between the LED coder's own modules: tick, pattern request, flash.
// Assumes all three parties run on the same mclk.
`timescale 1ns/1ps
`default_nettype none
interface sled_flash_if;
  import sled_pkg::*;
  logic      tick;
  logic      pat_run;
  sled_pat_t pat_sel;
  logic      flash;

  modport tickgen (output tick);
  modport player  (input tick, input pat_run, input pat_sel, output flash);
  modport ctrl    (input tick, input flash, output pat_run, output pat_sel);
endinterface : sled_flash_if
`default_nettype wire

// file: logic/sled_tick.sv
// Divider giving a one-cycle 10 ms tick enable.
// Assumes mclk at 40 MHz; TICK_CYCLES may be cut down for simulation.
`timescale 1ns/1ps
`default_nettype none
module sled_tick
  import sled_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic     mclk,
  input  wire logic     reset,
  sled_flash_if.tickgen fl
);
  localparam int unsigned CW = $clog2(TICK_CYCLES + 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          tick_q, tick_d;

  always_comb begin
    tick_d = (cnt_q == CW'(TICK_CYCLES - 1));
    cnt_d  = tick_d ? '0 : cnt_q + CW'(1);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign fl.tick = tick_q;
endmodule : sled_tick
`default_nettype wire

// file: logic/sled_player.sv
// Plays one flash pattern from the table, repeating with a pause.
// Assumes the controller holds pat_sel steady while pat_run is high.
`timescale 1ns/1ps
`default_nettype none
module sled_player
  import sled_pkg::*;
(
  input  wire logic    mclk,
  input  wire logic    reset,
  sled_flash_if.player fl
);
  typedef enum logic [3:0] {
    P_IDLE  = 4'b0001,
    P_ON    = 4'b0010,
    P_GAP   = 4'b0100,
    P_PAUSE = 4'b1000
  } sled_pstate_t;

  sled_pstate_t st_q, st_d;
  logic [3:0]   idx_q, idx_d;
  logic [7:0]   cnt_q, cnt_d;
  sled_pat_t    sel_q, sel_d;
  logic         flash_q, flash_d;
  sled_elem_t   el;

  always_comb begin
    st_d    = st_q;
    idx_d   = idx_q;
    cnt_d   = cnt_q;
    sel_d   = sel_q;
    el      = sled_pat_elem(sel_q, idx_q);
    case (st_q)
      P_IDLE: begin
        idx_d = 4'h0;
        sel_d = fl.pat_sel;
        if (fl.pat_run) begin
          st_d  = P_GAP;
          cnt_d = 8'h01;
        end
      end
      P_ON: begin
        if (fl.tick && cnt_q <= 8'h01) begin
          st_d  = P_GAP;
          cnt_d = GAP_TICKS;
          idx_d = idx_q + 4'h1;
        end else if (fl.tick) begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      P_GAP, P_PAUSE: begin
        if (fl.tick && cnt_q <= 8'h01) begin
          // Fetch the next element; the pause restarts the table
          if (st_q == P_PAUSE) begin
            idx_d = 4'h0;
            el    = sled_pat_elem(sel_q, 4'h0);
          end
          case (el)
            EL_SHORT: begin
              st_d  = P_ON;
              cnt_d = SHORT_TICKS;                      // [R12]
            end
            EL_LONG: begin
              st_d  = P_ON;
              cnt_d = LONG_TICKS;                       // [R12]
            end
            default: begin
              st_d  = P_PAUSE;
              cnt_d = PAUSE_TICKS;
            end
          endcase
        end else if (fl.tick) begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = P_IDLE;
    endcase
    // A new request or a dropped one restarts from the top
    if (!fl.pat_run || fl.pat_sel != sel_q) begin
      st_d = P_IDLE;
    end
    flash_d = (st_d == P_ON);
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_q    <= P_IDLE;
      idx_q   <= 4'h0;
      cnt_q   <= 8'h00;
      sel_q   <= PAT_SOS;
      flash_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      idx_q   <= idx_d;
      cnt_q   <= cnt_d;
      sel_q   <= sel_d;
      flash_q <= flash_d;
    end
  end

  assign fl.flash = flash_q;
endmodule : sled_player
`default_nettype wire

// file: logic/sled_coder.sv
// Status LED flash coder for a bus coupler or a measurement module.
// Assumes all inputs come from controller logic on mclk; no synchronisers.
//
// Operation
// R01: Coupler LED A off, 0.4 Hz, 1.2 Hz, flicker or on per fieldbus state.
// R02: LED C shows backplane activity; port LEDs show upstream and downstream.
// R03: After the 15 s switch-on with a good link, LED A stays lit.
// R04: Module in normal operation keeps all three LEDs steadily on.
// R05: Module shows SOS pattern on configuration mismatch with socket memory.
// R06: Mismatch raised when hot-swap expects data but socket holds none.
// R07: Mismatch raised when stored module type differs from inserted type.
// R08: A new configuration is written automatically into socket memory.
// R09: Firmware download shows its own non-error flash pattern.
// R10: Firmware activation sweeps LEDs top to bottom, then restarts module.
// R11: Communication faults give irregular flashes on the blue LED.
// R12: Patterns use two pulse lengths, short and long.
// R13: All flash lengths, gaps and rates are constants from the clock.
`timescale 1ns/1ps
`default_nettype none
module sled_coder
  import sled_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              coupler_role,
  input  wire logic [2:0]        fb_state,
  input  wire logic              link_ok,
  input  wire logic              upstream_act,
  input  wire logic              downstream_act,
  input  wire logic              lvds_act,
  input  wire logic              hotswap_en,
  input  wire logic              cfg_expected,
  input  wire logic              socket_cfg_valid,
  input  wire logic [TYPE_W-1:0] socket_type,
  input  wire logic [TYPE_W-1:0] module_type,
  input  wire logic              new_cfg_valid,
  input  wire logic [CFG_W-1:0]  new_cfg_data,
  input  wire logic              nvm_wr_ack,
  input  wire logic              fw_download,
  input  wire logic              fw_activate,
  input  wire logic              reconfig_done,
  input  wire logic              comm_error,
  output logic                   led_a,
  output logic                   led_b,
  output logic                   led_c,
  output logic                   upstream_port_led,
  output logic                   downstream_port_led,
  output logic                   nvm_wr_req,
  output logic [TYPE_W-1:0]      nvm_wr_type,
  output logic [CFG_W-1:0]       nvm_wr_data,
  output logic                   module_restart,
  output logic                   switch_on_done
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Tick-paced down counter; a reload wins over the count
  function automatic logic [7:0] sled_count(input logic [7:0] cnt,
                                            input logic       load,
                                            input logic [7:0] val,
                                            input logic       tick);
    logic [7:0] r;
    r = cnt;
    if (load)                    r = val;
    else if (tick && cnt != 8'h00) r = cnt - 8'h01;
    return r;
  endfunction : sled_count

  // ----------------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------------
  sled_flash_if fl ();

  sled_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk  (mclk),
    .reset (reset),
    .fl    (fl.tickgen)
  );

  sled_player u_player (
    .mclk  (mclk),
    .reset (reset),
    .fl    (fl.player)
  );

  // ----------------------------------------------------------------------
  // Switch-on timer
  // ----------------------------------------------------------------------
  logic [10:0] swon_q, swon_d;
  logic        swdone_q, swdone_d;

  always_comb begin
    swon_d   = swon_q;
    swdone_d = swdone_q;
    if (fl.tick && !swdone_q) begin
      swon_d = swon_q + 11'h001;
      if (swon_q == SWON_TICKS - 11'h001) begin
        swdone_d = 1'b1;                                // [R03]
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      swon_q   <= 11'h000;
      swdone_q <= 1'b0;
    end else begin
      swon_q   <= swon_d;
      swdone_q <= swdone_d;
    end
  end

  // ----------------------------------------------------------------------
  // Coupler state blinker
  // ----------------------------------------------------------------------
  logic [7:0] blk_q, blk_d;
  logic       blink_q, blink_d;
  logic [2:0] fbp_q, fbp_d;
  logic [7:0] half;

  always_comb begin
    case (fb_state)
      FB_PREOP:  half = PREOP_TICKS;                    // [R01] [R13]
      FB_SAFEOP: half = SAFEOP_TICKS;                   // [R01] [R13]
      FB_BOOT:   half = FLICKER_TICKS;                  // [R01] [R13]
      default:   half = PREOP_TICKS;
    endcase
    fbp_d   = fb_state;
    blink_d = blink_q;
    blk_d   = blk_q;
    if (fb_state != fbp_q) begin
      // Start each new rate with a lit half period
      blink_d = 1'b1;
      blk_d   = half;
    end else if (fl.tick && blk_q <= 8'h01) begin
      blink_d = !blink_q;
      blk_d   = half;
    end else begin
      blk_d = sled_count(blk_q, 1'b0, half, fl.tick);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blk_q   <= 8'h00;
      blink_q <= 1'b0;
      fbp_q   <= FB_INIT;
    end else begin
      blk_q   <= blk_d;
      blink_q <= blink_d;
      fbp_q   <= fbp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Activity stretchers
  // ----------------------------------------------------------------------
  // Single-cycle activity pulses would be invisible without stretching
  logic [7:0] up_q, up_d;
  logic [7:0] dn_q, dn_d;
  logic [7:0] lv_q, lv_d;

  always_comb begin
    up_d = sled_count(up_q, upstream_act, ACT_TICKS, fl.tick);   // [R02]
    dn_d = sled_count(dn_q, downstream_act, ACT_TICKS, fl.tick); // [R02]
    lv_d = sled_count(lv_q, lvds_act, ACT_TICKS, fl.tick);       // [R02]
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      up_q <= 8'h00;
      dn_q <= 8'h00;
      lv_q <= 8'h00;
    end else begin
      up_q <= up_d;
      dn_q <= dn_d;
      lv_q <= lv_d;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration check and socket memory write
  // ----------------------------------------------------------------------
  logic              cfg_err;
  logic              wr_q, wr_d;
  logic [TYPE_W-1:0] wtype_q, wtype_d;
  logic [CFG_W-1:0]  wdata_q, wdata_d;

  always_comb begin
    cfg_err = (hotswap_en && cfg_expected && !socket_cfg_valid)   // [R06]
            || (socket_cfg_valid && socket_type != module_type);  // [R07]
    wr_d    = wr_q;
    wtype_d = wtype_q;
    wdata_d = wdata_q;
    if (nvm_wr_ack) begin
      wr_d = 1'b0;
    end
    // A fresh configuration beats an acknowledge in the same cycle
    if (new_cfg_valid && !coupler_role) begin
      wr_d    = 1'b1;                                   // [R08]
      wtype_d = module_type;
      wdata_d = new_cfg_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_q    <= 1'b0;
      wtype_q <= '0;
      wdata_q <= '0;
    end else begin
      wr_q    <= wr_d;
      wtype_q <= wtype_d;
      wdata_q <= wdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Firmware activation sweep and restart
  // ----------------------------------------------------------------------
  logic [7:0] swp_q, swp_d;
  logic [2:0] pos_q, pos_d;
  logic       rst_q, rst_d;

  always_comb begin
    swp_d = swp_q;
    pos_d = pos_q;
    rst_d = 1'b0;
    if (!fw_activate || coupler_role) begin
      swp_d = SWEEP_TICKS;
      pos_d = 3'b100;
    end else if (fl.tick && swp_q <= 8'h01) begin
      swp_d = SWEEP_TICKS;
      pos_d = {pos_q[0], pos_q[2:1]};                   // [R10]
    end else begin
      swp_d = sled_count(swp_q, 1'b0, SWEEP_TICKS, fl.tick);
    end
    if (fw_activate && reconfig_done && !coupler_role) begin
      rst_d = 1'b1;                                     // [R10]
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      swp_q <= 8'h00;
      pos_q <= 3'b100;
      rst_q <= 1'b0;
    end else begin
      swp_q <= swp_d;
      pos_q <= pos_d;
      rst_q <= rst_d;
    end
  end

  // ----------------------------------------------------------------------
  // Pattern request and LED drive
  // ----------------------------------------------------------------------
  logic [2:0] leds_q, leds_d;
  logic       upl_q, upl_d;
  logic       dnl_q, dnl_d;

  always_comb begin
    fl.pat_run = !coupler_role && !fw_activate
               && (fw_download || cfg_err || comm_error);
    if (fw_download)      fl.pat_sel = PAT_DNLD;        // [R09]
    else if (cfg_err)     fl.pat_sel = PAT_SOS;         // [R05]
    else                  fl.pat_sel = PAT_COMM;        // [R11]

    upl_d = coupler_role && up_q != 8'h00;              // [R02]
    dnl_d = coupler_role && dn_q != 8'h00;              // [R02]
    if (coupler_role) begin
      leds_d[1] = 1'b1;
      leds_d[0] = lv_q != 8'h00;                        // [R02]
      if (swdone_q && link_ok) begin
        leds_d[2] = 1'b1;                               // [R03]
      end else begin
        case (fb_state)
          FB_INIT:  leds_d[2] = 1'b0;                   // [R01]
          FB_OP:    leds_d[2] = 1'b1;                   // [R01]
          FB_PREOP, FB_SAFEOP, FB_BOOT:
                    leds_d[2] = blink_q;                // [R01]
          default:  leds_d[2] = 1'b0;
        endcase
      end
    end else if (fw_activate) begin
      leds_d = pos_q;                                   // [R10]
    end else if (fw_download || cfg_err) begin
      leds_d = {3{fl.flash}};                           // [R05] [R09]
    end else if (comm_error) begin
      leds_d = {fl.flash, 2'b00};                       // [R11]
    end else begin
      leds_d = 3'b111;                                  // [R04]
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      leds_q <= 3'b000;
      upl_q  <= 1'b0;
      dnl_q  <= 1'b0;
    end else begin
      leds_q <= leds_d;
      upl_q  <= upl_d;
      dnl_q  <= dnl_d;
    end
  end

  assign led_a               = leds_q[2];
  assign led_b               = leds_q[1];
  assign led_c               = leds_q[0];
  assign upstream_port_led   = upl_q;
  assign downstream_port_led = dnl_q;
  assign nvm_wr_req          = wr_q;
  assign nvm_wr_type         = wtype_q;
  assign nvm_wr_data         = wdata_q;
  assign module_restart      = rst_q;
  assign switch_on_done      = swdone_q;

endmodule : sled_coder
`default_nettype wire

// file: bench/sled_coder_assertions.sv
// Port-level assertions for the status LED coder.
// Assumes binding into sled_coder; single mclk domain.
`timescale 1ns/1ps
`default_nettype none
module sled_coder_assertions
  import sled_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              coupler_role,
  input wire logic [2:0]        fb_state,
  input wire logic              link_ok,
  input wire logic              lvds_act,
  input wire logic              hotswap_en,
  input wire logic              cfg_expected,
  input wire logic              socket_cfg_valid,
  input wire logic [TYPE_W-1:0] socket_type,
  input wire logic [TYPE_W-1:0] module_type,
  input wire logic              new_cfg_valid,
  input wire logic [CFG_W-1:0]  new_cfg_data,
  input wire logic              nvm_wr_ack,
  input wire logic              fw_download,
  input wire logic              fw_activate,
  input wire logic              reconfig_done,
  input wire logic              comm_error,
  input wire logic              led_a,
  input wire logic              led_b,
  input wire logic              led_c,
  input wire logic              nvm_wr_req,
  input wire logic [CFG_W-1:0]  nvm_wr_data,
  input wire logic              module_restart,
  input wire logic              switch_on_done
);
  logic cfg_err;
  logic mod_ok;
  assign cfg_err = (hotswap_en & cfg_expected & ~socket_cfg_valid)
                 | (socket_cfg_valid & (socket_type != module_type));
  assign mod_ok = ~coupler_role & ~fw_activate & ~fw_download & ~cfg_err;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------------
  // Module role
  // ----------------------------------------------------------------------
  property p_normal;
    mod_ok && !comm_error |=> {led_a, led_b, led_c} == 3'h7;
  endproperty
  a_normal: assert property (p_normal) else $error("leds not on");
  property p_comm;
    mod_ok && comm_error |=> !led_b && !led_c;
  endproperty
  a_comm: assert property (p_comm) else $error("b or c lit");
  property p_sweep;
    !coupler_role && $rose(fw_activate) |=> {led_a, led_b, led_c} == 3'h4;
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep not at top");
  property p_restart;
    !coupler_role && fw_activate && reconfig_done |=> module_restart;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_nvm_take;
    !coupler_role && new_cfg_valid
      |=> nvm_wr_req && nvm_wr_data == $past(new_cfg_data);
  endproperty
  a_nvm_take: assert property (p_nvm_take) else $error("cfg lost");
  property p_nvm_hold;
    nvm_wr_req && !nvm_wr_ack |=> nvm_wr_req;
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("req dropped");
  property p_nvm_drop;
    nvm_wr_req && nvm_wr_ack && !new_cfg_valid |=> !nvm_wr_req;
  endproperty
  a_nvm_drop: assert property (p_nvm_drop) else $error("req stuck");

  // ----------------------------------------------------------------------
  // Coupler role
  // ----------------------------------------------------------------------
  property p_init;
    coupler_role && fb_state == 3'h0 && !(switch_on_done && link_ok)
      |=> !led_a;
  endproperty
  a_init: assert property (p_init) else $error("led a lit in init");
  property p_swon;
    coupler_role && switch_on_done && link_ok |=> led_a;
  endproperty
  a_swon: assert property (p_swon) else $error("led a dark after on");
  property p_act;
    coupler_role && lvds_act |=> ##[0:1] led_c;
  endproperty
  a_act: assert property (p_act) else $error("led c missed activity");

  c_sos: cover property (cfg_err && !fw_download && !fw_activate);
  c_nvm: cover property (new_cfg_valid ##1 nvm_wr_req);
  c_rst: cover property (module_restart);
endmodule : sled_coder_assertions

bind sled_coder sled_coder_assertions sled_coder_assertions_inst (.*);
`default_nettype wire

// file: bench/sled_panel_model.sv
// Front panel model: measures how long LED A stays lit per flash.
// Assumes LED outputs registered on mclk.
`timescale 1ns/1ps
`default_nettype none
module sled_panel_model (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        led_a,
  output logic [31:0]      on_len,
  output logic [31:0]      n_flash
);
  logic [31:0] run;
  // Length is latched when the LED goes dark, so steady-on never reports
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      run <= 32'h0;
      on_len <= 32'h0;
      n_flash <= 32'h0;
    end else if (led_a) begin
      run <= run + 32'h1;
    end else if (run != 32'h0) begin
      on_len <= run;
      n_flash <= n_flash + 32'h1;
      run <= 32'h0;
    end
  end
endmodule : sled_panel_model
`default_nettype wire

// file: bench/sled_coder_tb.sv
// Self-checking bench for the status LED coder.
// Assumes a shortened tick so the switch-on count fits the run.
`timescale 1ns/1ps
`default_nettype none
module sled_coder_tb;
  import sled_pkg::*;
  localparam int TC = 4;
  logic mclk = 0, reset = 1, coupler_role = 0, link_ok = 0;
  logic [2:0] fb_state = 3'h0;
  logic upstream_act = 0, downstream_act = 0, lvds_act = 0;
  logic hotswap_en = 0, cfg_expected = 0, socket_cfg_valid = 0;
  logic [TYPE_W-1:0] socket_type = 8'h00, module_type = 8'h00;
  logic new_cfg_valid = 0, nvm_wr_ack = 0, reconfig_done = 0;
  logic [CFG_W-1:0] new_cfg_data = 32'h0;
  logic fw_download = 0, fw_activate = 0, comm_error = 0;
  logic led_a, led_b, led_c, upstream_port_led, downstream_port_led;
  logic nvm_wr_req, module_restart, switch_on_done;
  logic [TYPE_W-1:0] nvm_wr_type;
  logic [CFG_W-1:0] nvm_wr_data;
  logic [31:0] on_len, n_flash;
  int num_errors = 0, n_tests = 0;
  integer seed = 32'hcb8c2f8d;
  // Expected flash lengths in ticks, per pattern
  int sos[$] = {20, 20, 20, 60, 60, 60, 20, 20, 20};
  int dnld[$] = {20, 60, 20, 60};
  int comm[$] = {20, 20, 60, 20, 60, 60, 20};
  int half[3] = '{125, 41, 5};

  always #12.5 mclk = ~mclk;

  sled_coder #(.TICK_CYCLES(TC)) sled_coder_inst (.*);
  sled_panel_model sled_panel_model_inst (.mclk, .reset, .led_a, .on_len,
                                          .n_flash);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic norm();
    cyc(3);
    check({led_a, led_b, led_c}, 3'h7);
  endtask : norm

  // Zero length skips the compare: a flash cut by a state change
  task automatic flash(input int tk, input logic allp);
    int c, w;
    logic sc;
    c = n_flash;
    w = 0;
    sc = 0;
    while (n_flash == c && w < 20000) begin
      @(negedge mclk);
      sc |= led_c;
      w++;
    end
    if (tk > 0) begin
      check((on_len + TC / 2) / TC, tk);
      check(sc, allp);
    end
  endtask : flash

  task automatic play(input int q[$], input logic allp);
    cyc(3);
    foreach (q[i]) flash(q[i], allp);
  endtask : play

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (16) @(negedge mclk);
    reset = 0;
    norm();
    hotswap_en = 1;
    cfg_expected = 1;
    play(sos, 1);
    hotswap_en = 0;
    norm();
    socket_type = 8'($random(seed));
    module_type = socket_type ^ 8'h5a;
    socket_cfg_valid = 1;
    play(sos[0:2], 1);
    module_type = socket_type;
    norm();
    fw_download = 1;
    play(dnld, 1);
    fw_download = 0;
    norm();
    comm_error = 1;
    play(comm, 0);
    comm_error = 0;
    norm();
    fw_activate = 1;
    cyc(1);
    check({led_a, led_b, led_c}, 3'h4);
    cyc(45 * TC);
    check({led_a, led_b, led_c}, 3'h2);
    cyc(30 * TC);
    check({led_a, led_b, led_c}, 3'h1);
    reconfig_done = 1;
    cyc(1);
    reconfig_done = 0;
    check(module_restart, 1);
    fw_activate = 0;
    new_cfg_data = $random(seed);
    new_cfg_valid = 1;
    cyc(1);
    new_cfg_valid = 0;
    check({nvm_wr_req, nvm_wr_type}, {1'b1, module_type});
    check(nvm_wr_data, new_cfg_data);
    cyc(2);
    check(nvm_wr_req, 1);
    nvm_wr_ack = 1;
    cyc(1);
    nvm_wr_ack = 0;
    check(nvm_wr_req, 0);
    coupler_role = 1;
    cyc(3);
    check(led_a, 0);
    for (int i = 0; i < 3; i++) begin
      fb_state = 3'(i + 1);
      cyc(3);
      flash(0, 0);
      flash(half[i], 0);
    end
    fb_state = 3'h4;
    cyc(3);
    check(led_a, 1);
    for (int i = 0; i < 3; i++) begin
      {lvds_act, upstream_act, downstream_act} = 3'h4 >> i;
      cyc(1);
      {lvds_act, upstream_act, downstream_act} = 3'h0;
      cyc(1);
      check({led_c,upstream_port_led,downstream_port_led}, 3'h4 >> i);
      cyc(8 * TC);
    end
    fb_state = 3'h0;
    for (int w = 0; w < 8000 && switch_on_done !== 1'b1; w++) cyc(1);
    link_ok = 1;
    cyc(2);
    check({switch_on_done, led_a}, 2'h3);
    end_of_test();
  end
endmodule : sled_coder_tb
`default_nettype wire
